/* gpbz_regs.svh */
// Purpose: register offsets, field positions and reset values for the GPIO block
// Assumes: 8-bit CPU data-memory bus, byte addresses as printed
// Notes:   included by the design modules and the testbench
`ifndef GPBZ_REGS_SVH
`define GPBZ_REGS_SVH

// ==========================================================
// Register offsets
`define GPBZ_ADDR_PA_DATA 8'h12
`define GPBZ_ADDR_PA_DIR  8'h13
`define GPBZ_ADDR_PB_DATA 8'h14
`define GPBZ_ADDR_PB_DIR  8'h15
`define GPBZ_ADDR_PC_DATA 8'h16
`define GPBZ_ADDR_PC_DIR  8'h17
`define GPBZ_ADDR_PD_DATA 8'h18
`define GPBZ_ADDR_PD_DIR  8'h19
`define GPBZ_ADDR_PG_DATA 8'h1e
`define GPBZ_ADDR_PG_DIR  8'h1f

// ==========================================================
// Field positions and reset values
`define GPBZ_PB_BZ_BIT    0
`define GPBZ_PB_BZN_BIT   1
`define GPBZ_PG_MASK      8'h01
`define GPBZ_DIR_RESET    8'hff
`define GPBZ_DATA_RESET   8'hff
`define GPBZ_NPORTS       5

`endif

/* gpbz_pkg.sv */
// Purpose: shared types for the GPIO block
// Assumes: constants come from gpbz_regs.svh
// Notes:   port index enumeration used by the address decoder
package gpbz_pkg;

	// ==========================================================
	// Types
	typedef logic [7:0] gpbz_byte_t;

	typedef enum logic [2:0] {
		GPBZ_PORT_A,
		GPBZ_PORT_B,
		GPBZ_PORT_C,
		GPBZ_PORT_D,
		GPBZ_PORT_G,
		GPBZ_PORT_NONE
	} gpbz_port_e;

endpackage : gpbz_pkg

/* gpbz_port_bank.sv */
// Purpose: one 8-bit port: data latch, direction register, read mux
// Assumes: one write strobe per register, synchronous reset
// Notes:   IMPL_MASK removes absent bits entirely
`timescale 1ns/1ps
`include "gpbz_regs.svh"

module gpbz_port_bank #(
	parameter logic [7:0] IMPL_MASK = 8'hff
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic                 data_we,
	input  wire logic                 dir_we,
	input  wire gpbz_pkg::gpbz_byte_t wdata,
	input  wire gpbz_pkg::gpbz_byte_t pad_in,
	output logic [7:0]                latch_q,
	output logic [7:0]                dir_q,
	output logic [7:0]                data_rd,
	output logic [7:0]                dir_rd
);
	import gpbz_pkg::*;

	logic [7:0] latch_d;
	logic [7:0] dir_d;

	// ==========================================================
	// Next state: latch holds until rewritten, absent bits never set
	always_comb
	begin
		latch_d = latch_q;
		dir_d   = dir_q;
		if (data_we)
			latch_d = wdata & IMPL_MASK;
		if (dir_we)
			dir_d = wdata & IMPL_MASK;
	end

	// Registers; reset leaves every line an input
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			latch_q <= `GPBZ_DATA_RESET & IMPL_MASK;
			dir_q   <= `GPBZ_DIR_RESET & IMPL_MASK;
		end
		else
		begin
			latch_q <= latch_d;
			dir_q   <= dir_d;
		end
	end

	// Per-bit read source: pad when input, latch when output
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_rd
			assign data_rd[i] = IMPL_MASK[i] & (dir_q[i] ? pad_in[i] : latch_q[i]);
		end
	endgenerate

	assign dir_rd = dir_q & IMPL_MASK;

endmodule : gpbz_port_bank

/* gpbz_gpio.sv */
// Purpose: five GPIO ports on CPU data memory, buzzer share on port B, interrupt share on port G
// Assumes: CPU bus gives address, read strobe and write strobe for one byte per cycle
// Notes:   bit and complement instructions are CPU read then write, seen here as two accesses
`timescale 1ns/1ps
`include "gpbz_regs.svh"

module gpbz_gpio (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire gpbz_pkg::gpbz_byte_t cpu_addr,
	input  wire logic                 cpu_rd,
	input  wire logic                 cpu_wr,
	input  wire gpbz_pkg::gpbz_byte_t cpu_wdata,
	output gpbz_pkg::gpbz_byte_t      cpu_rdata,
	output logic                      cpu_hit,
	input  wire logic                 buzzer_opt,
	input  wire logic                 tmr0_ovf,
	input  wire logic [7:0]           wake_en_opt,
	input  wire logic                 halted,
	output logic                      wake_up,
	output logic                      ext_int_n,
	input  wire logic [7:0]           pa_in,
	output logic [7:0]                pa_out,
	output logic [7:0]                pa_oe,
	input  wire logic [7:0]           pb_in,
	output logic [7:0]                pb_out,
	output logic [7:0]                pb_oe,
	input  wire logic [7:0]           pc_in,
	output logic [7:0]                pc_out,
	output logic [7:0]                pc_oe,
	input  wire logic [7:0]           pd_in,
	output logic [7:0]                pd_out,
	output logic [7:0]                pd_oe,
	input  wire logic                 pg_in,
	output logic                      pg_out,
	output logic                      pg_oe,
	input  wire logic [7:0]           pullup_a_opt,
	input  wire logic [7:0]           pullup_b_opt,
	input  wire logic [7:0]           pullup_c_opt,
	input  wire logic [7:0]           pullup_d_opt,
	input  wire logic                 pullup_g_opt,
	output logic [32:0]               pullup_en
);
	import gpbz_pkg::*;

	// ==========================================================
	// Address decode
	gpbz_port_e sel;
	logic       sel_dir;
	logic [4:0] data_we;
	logic [4:0] dir_we;

	// If/else-if chain over the ten mapped bytes
	always_comb
	begin
		sel     = GPBZ_PORT_NONE;
		sel_dir = 1'b0;
		if (cpu_addr == `GPBZ_ADDR_PA_DATA)
			sel = GPBZ_PORT_A;
		else if (cpu_addr == `GPBZ_ADDR_PA_DIR)
		begin
			sel     = GPBZ_PORT_A;
			sel_dir = 1'b1;
		end
		else if (cpu_addr == `GPBZ_ADDR_PB_DATA)
			sel = GPBZ_PORT_B;
		else if (cpu_addr == `GPBZ_ADDR_PB_DIR)
		begin
			sel     = GPBZ_PORT_B;
			sel_dir = 1'b1;
		end
		else if (cpu_addr == `GPBZ_ADDR_PC_DATA)
			sel = GPBZ_PORT_C;
		else if (cpu_addr == `GPBZ_ADDR_PC_DIR)
		begin
			sel     = GPBZ_PORT_C;
			sel_dir = 1'b1;
		end
		else if (cpu_addr == `GPBZ_ADDR_PD_DATA)
			sel = GPBZ_PORT_D;
		else if (cpu_addr == `GPBZ_ADDR_PD_DIR)
		begin
			sel     = GPBZ_PORT_D;
			sel_dir = 1'b1;
		end
		else if (cpu_addr == `GPBZ_ADDR_PG_DATA)
			sel = GPBZ_PORT_G;
		else if (cpu_addr == `GPBZ_ADDR_PG_DIR)
		begin
			sel     = GPBZ_PORT_G;
			sel_dir = 1'b1;
		end
	end

	// Write strobes per port; a byte write also serves bit set/clear write-back
	always_comb
	begin
		data_we = 5'h00;
		dir_we  = 5'h00;
		if (cpu_wr && sel != GPBZ_PORT_NONE)
		begin
			if (sel_dir)
				dir_we[sel] = 1'b1;
			else
				data_we[sel] = 1'b1;
		end
	end

	// ==========================================================
	// Port banks
	logic [7:0] pad [5];
	logic [7:0] lat [5];
	logic [7:0] dir [5];
	logic [7:0] drd [5];
	logic [7:0] crd [5];

	assign pad[0] = pa_in;
	assign pad[1] = pb_in;
	assign pad[2] = pc_in;
	assign pad[3] = pd_in;
	assign pad[4] = {7'h00, pg_in};

	// Port G keeps only line 0; the other seven bits do not exist
	genvar p;
	generate
		for (p = 0; p < `GPBZ_NPORTS; p++)
		begin : g_port
			gpbz_port_bank #(
				.IMPL_MASK (p == 4 ? `GPBZ_PG_MASK : 8'hff)
			) u_bank (
				.mclk    (mclk),
				.rst     (rst),
				.data_we (data_we[p]),
				.dir_we  (dir_we[p]),
				.wdata   (cpu_wdata),
				.pad_in  (pad[p]),
				.latch_q (lat[p]),
				.dir_q   (dir[p]),
				.data_rd (drd[p]),
				.dir_rd  (crd[p])
			);
		end
	endgenerate

	// ==========================================================
	// Read path: data registered at the read edge, pad taken live
	gpbz_byte_t rdata_d;
	gpbz_byte_t rdata_q;
	logic       hit_d;
	logic       hit_q;

	// Unmapped addresses answer zero with no hit
	always_comb
	begin
		rdata_d = 8'h00;
		hit_d   = 1'b0;
		if (cpu_rd && sel != GPBZ_PORT_NONE)
		begin
			hit_d   = 1'b1;
			rdata_d = sel_dir ? crd[sel] : drd[sel];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rdata_q <= 8'h00;
			hit_q   <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			hit_q   <= hit_d;
		end
	end

	assign cpu_rdata = rdata_q;
	assign cpu_hit   = hit_q;

	// ==========================================================
	// Buzzer tone: timer 0 overflow toggles the divider output
	logic tone_q;
	logic tone_d;

	always_comb
	begin
		tone_d = tone_q ^ tmr0_ovf;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			tone_q <= 1'b0;
		else
			tone_q <= tone_d;
	end

	// ==========================================================
	// Pad drive: push-pull only, enable high while driving
	logic bz0_gate;
	logic [7:0] pb_drv;

	// Line 0 latch alone gates the tone on both buzzer pads
	always_comb
	begin
		bz0_gate = buzzer_opt & lat[1][`GPBZ_PB_BZ_BIT];
		pb_drv   = lat[1];
		if (buzzer_opt)
		begin
			pb_drv[`GPBZ_PB_BZ_BIT] = bz0_gate & tone_q;
			// Line 1 is in buzzer mode only when line 0 also outputs the tone
			if (!dir[1][`GPBZ_PB_BZ_BIT])
				pb_drv[`GPBZ_PB_BZN_BIT] = bz0_gate & ~tone_q;
		end
	end

	// Output enable is just the inverted direction; inputs never driven
	assign pa_oe  = ~dir[0];
	assign pb_oe  = ~dir[1];
	assign pc_oe  = ~dir[2];
	assign pd_oe  = ~dir[3];
	assign pg_oe  = ~dir[4][0];
	assign pa_out = lat[0];
	assign pb_out = pb_drv;
	assign pc_out = lat[2];
	assign pd_out = lat[3];
	assign pg_out = lat[4][0];

	// Pull-ups only matter on undriven lines; without one the line floats
	assign pullup_en = {pullup_g_opt & dir[4][0],
	                    pullup_d_opt & dir[3], pullup_c_opt & dir[2],
	                    pullup_b_opt & dir[1], pullup_a_opt & dir[0]};

	// ==========================================================
	// Wake-up and interrupt sharing
	logic [7:0] pa_prev_q;
	logic [7:0] pa_prev_d;
	logic       wake_q;
	logic       wake_d;

	// Any enabled port A input that changes level while halted wakes the core
	always_comb
	begin
		pa_prev_d = pa_in;
		wake_d    = halted & |(wake_en_opt & dir[0] & (pa_in ^ pa_prev_q));
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			pa_prev_q <= pa_in; // Track the pad from reset so no false edge follows it
			wake_q    <= 1'b0;
		end
		else
		begin
			pa_prev_q <= pa_prev_d;
			wake_q    <= wake_d;
		end
	end

	assign wake_up = wake_q;

	// The interrupt sees the pad level, which is the driven level in output mode
	assign ext_int_n = pg_oe ? pg_out : pg_in;

	// ==========================================================
	// Checks
	property p_pg_upper_zero;
		@(posedge mclk) disable iff (rst)
			(cpu_rd && cpu_addr == `GPBZ_ADDR_PG_DATA) |=> (cpu_rdata[7:1] == 7'h00);
	endproperty
	a_pg_upper_zero : assert property (p_pg_upper_zero) else $error("port g upper bits not zero");

	property p_latch_hold;
		@(posedge mclk) disable iff (rst)
			!data_we[2] |=> $stable(pc_out);
	endproperty
	a_latch_hold : assert property (p_latch_hold) else $error("latch changed without write");

	property p_rd_input;
		@(posedge mclk) disable iff (rst)
			(cpu_rd && cpu_addr == `GPBZ_ADDR_PC_DATA && dir[2] == 8'hff) |=> (cpu_rdata == $past(pc_in));
	endproperty
	a_rd_input : assert property (p_rd_input) else $error("input read not pad");

	property p_rd_output;
		@(posedge mclk) disable iff (rst)
			(cpu_rd && cpu_addr == `GPBZ_ADDR_PD_DATA && dir[3] == 8'h00) |=> (cpu_rdata == $past(lat[3]));
	endproperty
	a_rd_output : assert property (p_rd_output) else $error("output read not latch");

	property p_dir_write;
		@(posedge mclk) disable iff (rst)
			(cpu_wr && cpu_addr == `GPBZ_ADDR_PA_DIR) |=> (pa_oe == ~$past(cpu_wdata));
	endproperty
	a_dir_write : assert property (p_dir_write) else $error("direction write lost");

	property p_reset_inputs;
		@(posedge mclk) rst |=> (pa_oe == 8'h00 && pb_oe == 8'h00 && !pg_oe);
	endproperty
	a_reset_inputs : assert property (p_reset_inputs) else $error("line driven after reset");

	property p_bz_gate;
		@(posedge mclk) disable iff (rst)
			(buzzer_opt && !lat[1][0] && pb_oe[0]) |-> (pb_out[0] == 1'b0);
	endproperty
	a_bz_gate : assert property (p_bz_gate) else $error("buzzer not gated low");

	property p_bz_line1;
		@(posedge mclk) disable iff (rst)
			(buzzer_opt && dir[1][0] && !dir[1][1]) |-> (pb_out[1] == lat[1][1]);
	endproperty
	a_bz_line1 : assert property (p_bz_line1) else $error("line 1 not own latch");

	property p_wake;
		@(posedge mclk) disable iff (rst)
			(halted && wake_en_opt[0] && dir[0][0] && pa_in[0] != pa_prev_q[0]) |=> wake_up;
	endproperty
	a_wake : assert property (p_wake) else $error("port a change did not wake");

endmodule : gpbz_gpio

/* gpbz_pad_model.sv */
// Purpose: board and pad model facing the GPIO block
// Assumes: 33 pads packed {g0,d,c,b,a}; bench may drive any pad
// Notes:   undriven pads without pull-up toggle so stale reads show
`timescale 1ns/1ps

module gpbz_pad_model (
	input  wire logic        mclk,
	input  wire logic [32:0] out,
	input  wire logic [32:0] oe,
	input  wire logic [32:0] pu,
	input  wire logic [32:0] ext,
	input  wire logic [32:0] ext_en,
	output logic [32:0]      pad
);
	logic [32:0] float_q = '0;

	// ==========================================================
	// Floating level flips every cycle; a sim would settle X otherwise
	always @(posedge mclk)
	begin
		float_q <= ~float_q;
	end

	// Pad level: block output wins, then bench, pull-up, float
	always_comb
	begin
		for (int i = 0; i < 33; i++)
		begin
			if (oe[i])
				pad[i] = out[i];
			else if (ext_en[i])
				pad[i] = ext[i];
			else if (pu[i])
				pad[i] = 1'b1;
			else
				pad[i] = float_q[i];
		end
	end
endmodule : gpbz_pad_model

/* tb_gpio_ports_with_buzzer_share.sv */
// Purpose: self-checking bench for the GPIO block
// Assumes: one-cycle read/write strobes, read data one cycle later
// Notes:   pads resolved by the pad model; bench drives pads it owns
`timescale 1ns/1ps
`include "gpbz_regs.svh"

module tb_gpio_ports_with_buzzer_share;
	import gpbz_pkg::*;

	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        cpu_rd = 1'b0;
	logic        cpu_wr = 1'b0;
	logic        buzzer_opt = 1'b0;
	logic        tmr0_ovf = 1'b0;
	logic        halted = 1'b0;
	logic [7:0]  wake_en = 8'h00;
	gpbz_byte_t  cpu_addr = 8'h00;
	gpbz_byte_t  cpu_wdata = 8'h00;
	gpbz_byte_t  cpu_rdata;
	logic        cpu_hit;
	logic        wake_up;
	logic        ext_int_n;
	logic [32:0] pu_opt = 33'h0_f00f_a55a;
	logic [32:0] ext = 33'h1_3c5a_96a5;
	logic [32:0] ext_en = '1;
	logic [32:0] outs;
	logic [32:0] oes;
	logic [32:0] pad;
	logic [32:0] pullup_en;
	gpbz_byte_t  pat [5] = '{8'ha5, 8'h3c, 8'h0f, 8'hf0, 8'hfe};
	gpbz_byte_t  d;
	gpbz_byte_t  lat;
	logic        h;
	logic        t;
	int          failures = 0;
	int          checks = 0;

	always #5 mclk = ~mclk;

	gpbz_gpio uut (.mclk(mclk), .rst(rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
		.cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_hit(cpu_hit), .buzzer_opt(buzzer_opt),
		.tmr0_ovf(tmr0_ovf), .wake_en_opt(wake_en), .halted(halted), .wake_up(wake_up),
		.ext_int_n(ext_int_n), .pa_in(pad[7:0]), .pa_out(outs[7:0]), .pa_oe(oes[7:0]),
		.pb_in(pad[15:8]), .pb_out(outs[15:8]), .pb_oe(oes[15:8]), .pc_in(pad[23:16]),
		.pc_out(outs[23:16]), .pc_oe(oes[23:16]), .pd_in(pad[31:24]), .pd_out(outs[31:24]),
		.pd_oe(oes[31:24]), .pg_in(pad[32]), .pg_out(outs[32]), .pg_oe(oes[32]),
		.pullup_a_opt(pu_opt[7:0]), .pullup_b_opt(pu_opt[15:8]), .pullup_c_opt(pu_opt[23:16]),
		.pullup_d_opt(pu_opt[31:24]), .pullup_g_opt(pu_opt[32]), .pullup_en(pullup_en));

	gpbz_pad_model pads (.mclk(mclk), .out(outs), .oe(oes), .pu(pullup_en), .ext(ext),
		.ext_en(ext_en), .pad(pad));

	// ==========================================================
	// Helpers
	function automatic gpbz_byte_t sl(input logic [32:0] v, input int i);
		return (i == 4) ? {7'h00, v[32]} : v[8*i +: 8];
	endfunction : sl

	function automatic gpbz_byte_t da(input int i, input bit dir);
		return (i == 4) ? (8'h1e + 8'(dir)) : (8'h12 + 8'(2 * i) + 8'(dir));
	endfunction : da

	task automatic close_out;
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// Bus cycles: strobe for one edge, effect seen just after it
	task automatic wr(input gpbz_byte_t a, input gpbz_byte_t v);
		@(posedge mclk);
		cpu_addr <= a;
		cpu_wdata <= v;
		cpu_wr <= 1'b1;
		@(posedge mclk);
		cpu_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input gpbz_byte_t a);
		@(posedge mclk);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge mclk);
		cpu_rd <= 1'b0;
		#1;
		d = cpu_rdata;
		h = cpu_hit;
	endtask : rd

	task automatic rdc(input gpbz_byte_t a, input gpbz_byte_t exp, input bit hit);
		rd(a);
		chk(d, exp, "read data");
		chk(h, hit, "read hit");
	endtask : rdc

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk(oes, '0, "oe after reset");
		chk(outs, '1, "latch reset");
		chk(pullup_en, pu_opt, "pull-up");
		for (int i = 0; i < 5; i++)
		begin
			rdc(da(i, 1), (i == 4) ? 8'h01 : 8'hff, 1);
			rdc(da(i, 0), sl(ext, i), 1);
		end
		// Every line an output, also the spare ones
		for (int i = 0; i < 5; i++)
		begin
			wr(da(i, 0), pat[i]);
			wr(da(i, 1), 8'h00);
			rdc(da(i, 0), pat[i] & ((i == 4) ? 8'h01 : 8'hff), 1);
		end
		chk(outs, {1'b0, pat[3], pat[2], pat[1], pat[0]}, "outputs");
		chk(oes, '1, "all driving");
		chk(pullup_en, '0, "pull-up off");
		for (int i = 0; i < 2; i++)
			rdc(8'h1d + 8'(3 * i), 8'h00, 0);
		// Mixed direction, then read-modify-write bit operations
		wr(da(0, 1), 8'h0f);
		chk(outs[7:0], pat[0], "latch kept");
		lat = pat[0];
		for (int k = 0; k < 3; k++)
		begin
			lat = (ext[7:0] & 8'h0f) | (lat & 8'hf0);
			rdc(da(0, 0), lat, 1);
			lat = (k == 0) ? (lat | 8'h02) : (k == 1) ? (lat & 8'h7f) : ~lat;
			wr(da(0, 0), lat);
			chk(outs[7:0], lat, "bit op latch");
		end
		// Buzzer share on port B
		@(posedge mclk);
		buzzer_opt <= 1'b1;
		@(posedge mclk);
		#1;
		chk(outs[9:8], 2'b00, "tone gated off");
		wr(da(1, 0), 8'h3d);
		t = outs[8];
		chk(^outs[9:8], 1'b1, "tone complement");
		@(posedge mclk);
		tmr0_ovf <= 1'b1;
		@(posedge mclk);
		tmr0_ovf <= 1'b0;
		#1;
		chk(outs[9:8], {t, ~t}, "tone flip");
		chk(outs[15:10], 6'h0f, "plain bits");
		wr(da(1, 1), 8'h01);
		chk(outs[9], 1'b0, "line1 own latch");
		// Flip the tone so a line 1 still on the buzzer would show high in one of the two states
		@(posedge mclk);
		tmr0_ovf <= 1'b1;
		@(posedge mclk);
		tmr0_ovf <= 1'b0;
		#1;
		chk(outs[9], 1'b0, "line1 own latch after flip");
		for (int k = 1; k < 4; k += 2)
		begin
			wr(da(1, 1), 8'(k));
			rdc(da(1, 0), (ext[15:8] & 8'(k)) | (8'h3d & ~8'(k)), 1);
		end
		// Wake from halt on port A, enabled bit only
		wr(da(0, 1), 8'hff);
		@(posedge mclk);
		halted <= 1'b1;
		wake_en <= 8'h01;
		repeat (3) @(posedge mclk);
		ext[1] <= ~ext[1];
		repeat (4)
		begin
			@(posedge mclk);
			#1;
			chk(wake_up, 1'b0, "no wake");
		end
		@(posedge mclk);
		ext[0] <= ~ext[0];
		for (int n = 0; n <= 4 && wake_up !== 1'b1; n++)
		begin
			@(posedge mclk);
			#1;
			if (n == 4)
			begin
				chk(wake_up, 1'b1, "wake timeout");
				close_out();
			end
		end
		chk(wake_up, 1'b1, "wake");
		// Interrupt input shares port G line 0
		wr(da(4, 1), 8'h01);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge mclk);
			ext[32] <= k[0];
			#1;
			chk(ext_int_n, k[0], "int pad");
		end
		close_out();
	end
endmodule : tb_gpio_ports_with_buzzer_share
